// ===== rtl/vcfa_pkg.sv
// Constants, encoding layout and types for the control-structure field access block.
// Assumes a single core clock; every user of it imports the whole package.
package vcfa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Field encoding layout
  localparam int ENC_RSVD_MSB   = 31;
  localparam int ENC_RSVD_LSB   = 15;
  localparam int ENC_WIDTH_MSB  = 14;
  localparam int ENC_WIDTH_LSB  = 13;
  localparam int ENC_RSVD_MID   = 12;
  localparam int ENC_TYPE_MSB   = 11;
  localparam int ENC_TYPE_LSB   = 10;
  localparam int ENC_INDEX_MSB  = 9;
  localparam int ENC_INDEX_LSB  = 1;
  localparam int ENC_ACCESS_BIT = 0;
  localparam int ENC_W          = 32;

  localparam logic [1:0] WIDTH_16  = 2'h0;
  localparam logic [1:0] WIDTH_64  = 2'h1;
  localparam logic [1:0] WIDTH_32  = 2'h2;
  localparam logic [1:0] WIDTH_NAT = 2'h3;

  localparam logic [1:0] TYPE_CTRL  = 2'h0;
  localparam logic [1:0] TYPE_RO    = 2'h1;
  localparam logic [1:0] TYPE_GUEST = 2'h2;
  localparam logic [1:0] TYPE_HOST  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field storage
  localparam int         FIELD_IDX_BITS  = 4;
  localparam logic [8:0] FIELD_IDX_LIMIT = 9'h010;
  localparam int         SLOT_AW         = 8;
  localparam int         FIELD_SLOTS     = 256;
  localparam logic [7:0] WALK_LAST       = 8'hFF;
  localparam int         FIELD_BYTE_SH   = 3;

  // Strap settle count after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_FLUSH = 2'h2,
    OP_LOAD  = 2'h3
  } vcfa_op_t;

endpackage

// ===== rtl/vcfa_if.sv
// Interfaces joining the top with its encoding decoder and field storage.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
`default_nettype none
interface vcfa_dec_if;
  import vcfa_pkg::*;
  logic [63:0]        enc;
  logic               long_mode;
  logic [1:0]         width;
  logic [1:0]         ftype;
  logic [8:0]         index;
  logic               high;
  logic [SLOT_AW-1:0] addr;
  logic               bad;
  modport dec  (input enc, long_mode, output width, ftype, index, high, addr, bad);
  modport user (output enc, long_mode, input width, ftype, index, high, addr, bad);
endinterface

interface vcfa_ram_if;
  import vcfa_pkg::*;
  logic               re;
  logic               we_lo;
  logic               we_hi;
  logic [SLOT_AW-1:0] addr;
  logic [63:0]        wdata;
  logic [63:0]        rdata;
  modport ram  (input re, we_lo, we_hi, addr, wdata, output rdata);
  modport user (output re, we_lo, we_hi, addr, wdata, input rdata);
endinterface
`default_nettype wire

// ===== rtl/vcfa_decode.sv
// Combinational decoder of a field encoding operand.
// Assumes the caller qualifies long_mode with the 64-bit capability.
`timescale 1ns/1ps
`default_nettype none
module vcfa_decode
  import vcfa_pkg::*;
(
  vcfa_dec_if.dec d
);

  logic rsvd_bad;
  logic upper_bad;
  logic access_bad;
  logic index_bad;

  always_comb begin
    rsvd_bad   = (d.enc[ENC_RSVD_MSB:ENC_RSVD_LSB] != '0) | d.enc[ENC_RSVD_MID];
    upper_bad  = d.long_mode & (d.enc[63:ENC_W] != '0);
    d.width    = d.enc[ENC_WIDTH_MSB:ENC_WIDTH_LSB];
    d.ftype    = d.enc[ENC_TYPE_MSB:ENC_TYPE_LSB];
    d.index    = d.enc[ENC_INDEX_MSB:ENC_INDEX_LSB];
    d.high     = d.enc[ENC_ACCESS_BIT];
    access_bad = d.high & (d.width != WIDTH_64);
    index_bad  = d.index >= FIELD_IDX_LIMIT;
    // Slot is type, width and index, so equal index in other width or type is distinct
    d.addr     = {d.ftype, d.width, d.index[FIELD_IDX_BITS-1:0]};
    d.bad      = rsvd_bad | upper_bad | access_bad | index_bad;
  end

endmodule // vcfa_decode
`default_nettype wire

// ===== rtl/vcfa_field_ram.sv
// Field storage: one 64-bit word per field slot, written in halves.
// Assumes one read or write per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module vcfa_field_ram
  import vcfa_pkg::*;
(
  input  wire logic   clk,
  vcfa_ram_if.ram     r
);

  // No reset on contents: software initializes every field before use
  logic [63:0] mem [0:FIELD_SLOTS-1];
  logic [63:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (r.we_lo) begin
      mem[r.addr][31:0] <= r.wdata[31:0];
    end
    if (r.we_hi) begin
      mem[r.addr][63:32] <= r.wdata[63:32];
    end
    if (r.re) begin
      rdata_reg <= mem[r.addr];
    end
  end

  assign r.rdata = rdata_reg;

endmodule // vcfa_field_ram
`default_nettype wire

// ===== rtl/vcfa_top.sv
// Field access engine for the virtual control structure of one logical processor.
// Assumes requests and long_mode come from core logic on clk; the strap is a pin.
`timescale 1ns/1ps
`default_nettype none
module vcfa_top
  import vcfa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ext64_strap,
  input  wire logic        long_mode,
  input  wire logic        req_valid,
  input  wire vcfa_op_t    req_op,
  input  wire logic [63:0] enc_operand,
  input  wire logic [63:0] src_data,
  output logic             req_ready,
  output logic             resp_valid,
  output logic             resp_fail,
  output logic [63:0]      rd_data,
  output logic             struct_active,
  output logic [63:0]      struct_region,
  output logic             ext64_cap,
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [63:0]      mem_wr_addr,
  output logic [63:0]      mem_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Types

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_RD_WAIT = 5'h02,
    ST_FL_RD   = 5'h04,
    ST_FL_CAP  = 5'h08,
    ST_FL_WR   = 5'h10
  } vcfa_state_t;

  typedef struct packed {
    vcfa_state_t        st;
    logic               strap_s1;
    logic               strap_s2;
    logic [1:0]         strap_cnt;
    logic               cap64;
    logic               cap_done;
    logic               active;
    logic [63:0]        region;
    logic [SLOT_AW-1:0] walk;
    logic [1:0]         rd_width;
    logic               rd_high;
    logic               rd_lm;
    logic               ready;
    logic               resp_valid;
    logic               resp_fail;
    logic [63:0]        rd_data;
    logic               mem_valid;
    logic [63:0]        mem_addr;
    logic [63:0]        mem_data;
  } vcfa_regs_t;

  vcfa_regs_t r_reg;
  vcfa_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////////
  // Data shaping

  // True when the field moves all 64 bits in the current mode
  function automatic logic wide_full(input logic [1:0] w, input logic lm);
    wide_full = lm & ((w == WIDTH_64) | (w == WIDTH_NAT));
  endfunction

  function automatic logic [63:0] shape_read(input logic [1:0] w, input logic hi,
                                             input logic lm, input logic [63:0] f);
    logic [63:0] v;
    v = 64'h0;
    if (hi) begin
      v = {32'h0, f[63:32]};
    end else if (w == WIDTH_16) begin
      v = {48'h0, f[15:0]};
    end else if (w == WIDTH_32) begin
      v = {32'h0, f[31:0]};
    end else if (wide_full(w, lm)) begin
      v = f;
    end else begin
      v = {32'h0, f[31:0]};
    end
    shape_read = v;
  endfunction

  function automatic logic [63:0] shape_write(input logic [1:0] w, input logic hi,
                                              input logic lm, input logic [63:0] s);
    logic [63:0] v;
    v = 64'h0;
    if (hi) begin
      v = {s[31:0], 32'h0};
    end else if (w == WIDTH_16) begin
      v = {48'h0, s[15:0]};
    end else if (w == WIDTH_32) begin
      v = {32'h0, s[31:0]};
    end else if (wide_full(w, lm)) begin
      v = s;
    end else begin
      v = {32'h0, s[31:0]};
    end
    shape_write = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  vcfa_dec_if dec_if ();
  vcfa_ram_if ram_if ();

  vcfa_decode u_decode (
    .d (dec_if.dec)
  );

  vcfa_field_ram u_ram (
    .clk (clk),
    .r   (ram_if.ram)
  );

  logic take;
  logic lm_eff;

  assign lm_eff           = long_mode & r_reg.cap64;
  assign take             = req_valid & r_reg.ready;
  assign dec_if.enc       = enc_operand;
  assign dec_if.long_mode = lm_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_next            = r_reg;
    r_next.resp_valid = 1'b0;
    r_next.resp_fail  = 1'b0;
    ram_if.re         = 1'b0;
    ram_if.we_lo      = 1'b0;
    ram_if.we_hi      = 1'b0;
    ram_if.addr       = dec_if.addr;
    ram_if.wdata      = shape_write(dec_if.width, dec_if.high, lm_eff, src_data);

    // Strap passes two flops, then is captured once after reset release and held until the next reset
    r_next.strap_s1 = ext64_strap;
    r_next.strap_s2 = r_reg.strap_s1;
    if (!r_reg.cap_done) begin
      if (r_reg.strap_cnt == STRAP_SETTLE) begin
        r_next.cap64    = r_reg.strap_s2;
        r_next.cap_done = 1'b1;
      end else begin
        r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
      end
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (take) begin
          case (req_op)
            OP_READ: begin
              // Field operations never touch referenced structures in memory
              if (dec_if.bad || !r_reg.active) begin
                r_next.resp_valid = 1'b1;
                r_next.resp_fail  = 1'b1;
              end else begin
                ram_if.re       = 1'b1;
                r_next.rd_width = dec_if.width;
                r_next.rd_high  = dec_if.high;
                r_next.rd_lm    = lm_eff;
                r_next.st       = ST_RD_WAIT;
              end
            end
            OP_WRITE: begin
              r_next.resp_valid = 1'b1;
              if (dec_if.bad || !r_reg.active) begin
                r_next.resp_fail = 1'b1;
              end else begin
                // High write keeps the low half untouched
                ram_if.we_lo = ~dec_if.high;
                ram_if.we_hi = 1'b1;
              end
            end
            OP_LOAD: begin
              // Loading over an active structure would lose its held data
              r_next.resp_valid = 1'b1;
              if (r_reg.active) begin
                r_next.resp_fail = 1'b1;
              end else begin
                r_next.active = 1'b1;
                r_next.region = src_data;
              end
            end
            default: begin
              // Flush of a structure not held here has nothing to write back
              if (r_reg.active && (src_data == r_reg.region)) begin
                r_next.walk = '0;
                r_next.st   = ST_FL_RD;
              end else begin
                r_next.resp_valid = 1'b1;
              end
            end
          endcase
        end
      end
      ST_RD_WAIT: begin
        r_next.rd_data    = shape_read(r_reg.rd_width, r_reg.rd_high, r_reg.rd_lm, ram_if.rdata);
        r_next.resp_valid = 1'b1;
        r_next.st         = ST_IDLE;
      end
      ST_FL_RD: begin
        ram_if.re   = 1'b1;
        ram_if.addr = r_reg.walk;
        r_next.st   = ST_FL_CAP;
      end
      ST_FL_CAP: begin
        r_next.mem_valid = 1'b1;
        r_next.mem_data  = ram_if.rdata;
        r_next.mem_addr  = r_reg.region + {53'h0, r_reg.walk, 3'h0};
        r_next.st        = ST_FL_WR;
      end
      ST_FL_WR: begin
        if (mem_wr_ready) begin
          r_next.mem_valid = 1'b0;
          if (r_reg.walk == WALK_LAST) begin
            r_next.active     = 1'b0;
            r_next.resp_valid = 1'b1;
            r_next.st         = ST_IDLE;
          end else begin
            r_next.walk = r_reg.walk + 8'h01;
            r_next.st   = ST_FL_RD;
          end
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    r_next.ready = (r_next.st == ST_IDLE) & r_next.cap_done & ~take;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '{st: ST_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_ready     = r_reg.ready;
  assign resp_valid    = r_reg.resp_valid;
  assign resp_fail     = r_reg.resp_fail;
  assign rd_data       = r_reg.rd_data;
  assign struct_active = r_reg.active;
  assign struct_region = r_reg.region;
  assign ext64_cap     = r_reg.cap64;
  assign mem_wr_valid  = r_reg.mem_valid;
  assign mem_wr_addr   = r_reg.mem_addr;
  assign mem_wr_data   = r_reg.mem_data;

endmodule // vcfa_top
`default_nettype wire

// ===== test/vcfa_properties.sv
// Concurrent checks on the field access top.
// Assumes one clock domain; sees only the top's ports.
`timescale 1ns/1ps
`default_nettype none
module vcfa_properties
  import vcfa_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ext64_strap,
  input wire logic        long_mode,
  input wire logic        req_valid,
  input wire vcfa_op_t    req_op,
  input wire logic [63:0] enc_operand,
  input wire logic [63:0] src_data,
  input wire logic        req_ready,
  input wire logic        resp_valid,
  input wire logic        resp_fail,
  input wire logic [63:0] rd_data,
  input wire logic        struct_active,
  input wire logic [63:0] struct_region,
  input wire logic        ext64_cap,
  input wire logic        mem_wr_valid,
  input wire logic        mem_wr_ready,
  input wire logic [63:0] mem_wr_addr,
  input wire logic [63:0] mem_wr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  logic       rw_take;
  logic       rd_take;
  logic       lm_eff;
  logic [1:0] w;
  assign rw_take = req_valid && req_ready && (req_op == OP_READ || req_op == OP_WRITE);
  assign rd_take = req_valid && req_ready && req_op == OP_READ;
  assign lm_eff  = long_mode && ext64_cap;
  assign w       = enc_operand[14:13];
  sequence fail_resp;
    resp_valid && resp_fail;
  endsequence
  // Good reads answer two edges after the take
  sequence good_rd;
    ##2 (resp_valid && !resp_fail);
  endsequence
  ////////////////////////////////////////
  rsvd_fail_a: assert property (rw_take && (enc_operand[31:15] != 17'h0 || enc_operand[12]) |=> fail_resp)
    else $error("reserved encoding bits accepted");
  upper_fail_a: assert property (rw_take && lm_eff && enc_operand[63:32] != 32'h0 |=> fail_resp)
    else $error("upper operand bits accepted in long mode");
  access_fail_a: assert property (rw_take && enc_operand[0] && w != WIDTH_64 |=> fail_resp)
    else $error("high access accepted on non 64-bit field");
  index_fail_a: assert property (rw_take && enc_operand[9:1] >= FIELD_IDX_LIMIT |=> fail_resp)
    else $error("missing field index accepted");
  rd16_zero_a: assert property (rd_take && w == WIDTH_16 ##0 good_rd |-> rd_data[63:16] == 48'h0)
    else $error("16-bit read upper bits not zero");
  rd32_zero_a: assert property (rd_take && w == WIDTH_32 ##0 good_rd |-> rd_data[63:32] == 32'h0)
    else $error("32-bit read upper bits not zero");
  rdhi_zero_a: assert property (rd_take && enc_operand[0] ##0 good_rd |-> rd_data[63:32] == 32'h0)
    else $error("high read upper bits not zero");
  narrow_rd_a: assert property (rd_take && !lm_eff && !enc_operand[0] && w[0] ##0 good_rd
    |-> rd_data[63:32] == 32'h0)
    else $error("narrow mode wide read upper bits not zero");
  wb_hold_a: assert property (mem_wr_valid && !mem_wr_ready
    |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("writeback dropped before ready");
  wb_addr_a: assert property (mem_wr_valid |-> mem_wr_addr[2:0] == 3'h0 && mem_wr_addr - struct_region < 64'h800)
    else $error("writeback address outside region");
  deact_a: assert property ($fell(struct_active) |-> resp_valid && !resp_fail)
    else $error("structure deactivated without flush response");
endmodule // vcfa_properties

bind vcfa_top vcfa_properties vcfa_properties_i (.clk, .sys_rst, .ext64_strap, .long_mode, .req_valid, .req_op,
  .enc_operand, .src_data, .req_ready, .resp_valid, .resp_fail, .rd_data, .struct_active, .struct_region,
  .ext64_cap, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data);
`default_nettype wire

// ===== test/vcfa_mem_model.sv
// Memory that takes flushed field slots from the top.
// Assumes a region aligned so address bits 10:3 give the slot.
`timescale 1ns/1ps
`default_nettype none
module vcfa_mem_model
  import vcfa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_wr_valid,
  input  wire logic [63:0] mem_wr_addr,
  input  wire logic [63:0] mem_wr_data,
  output logic             mem_wr_ready
);
  logic [63:0] mem [FIELD_SLOTS];
  int          n_wr;
  logic [1:0]  wait_cnt;
  // Slow mode stalls each word four cycles to stress the hold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr_ready <= 1'b0;
      wait_cnt     <= 2'h0;
      n_wr         <= 0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      // Only flush writebacks change this memory, never while a guest runs
      mem[mem_wr_addr[10:3]] <= mem_wr_data;
      n_wr                   <= n_wr + 1;
      mem_wr_ready           <= 1'b0;
      wait_cnt               <= 2'h0;
    end else if (mem_wr_valid) begin
      mem_wr_ready <= (wait_cnt == (slow ? 2'h3 : 2'h0));
      wait_cnt     <= wait_cnt + 2'h1;
    end
  end
endmodule // vcfa_mem_model
`default_nettype wire

// ===== test/vcfa_top_tb.sv
// Self-checking bench for the field access top.
// Assumes the memory model answers flush writebacks.
`timescale 1ns/1ps
`default_nettype none
module vcfa_top_tb;
  import vcfa_pkg::*;
  localparam logic [63:0] REGION = 64'h0000_0000_0004_0000;
  localparam logic [63:0] PAT    = 64'hFEDC_BA98_7654_3210;
  logic        clk = 1'b0, sys_rst = 1'b1, ext64_strap = 1'b1, long_mode = 1'b1, req_valid = 1'b0, slow = 1'b0;
  vcfa_op_t    req_op = OP_READ;
  logic [63:0] enc_operand = 64'h0, src_data = 64'h0, d;
  logic        req_ready, resp_valid, resp_fail, struct_active, ext64_cap, mem_wr_valid, mem_wr_ready, f;
  logic [63:0] rd_data, struct_region, mem_wr_addr, mem_wr_data;
  logic [63:0] e64, enat;
  int          num_errors = 0, n_checks = 0;
  always #10 clk = ~clk;
  vcfa_top vcfa_top_i (.clk, .sys_rst, .ext64_strap, .long_mode, .req_valid, .req_op, .enc_operand, .src_data,
    .req_ready, .resp_valid, .resp_fail, .rd_data, .struct_active, .struct_region, .ext64_cap, .mem_wr_valid,
    .mem_wr_ready, .mem_wr_addr, .mem_wr_data);
  vcfa_mem_model vcfa_mem_model_i (.clk, .sys_rst, .slow, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready);
  ////////////////////////////////////////
  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [63:0] mk(input logic [1:0] w, t, input logic [8:0] i, input logic h);
    return {49'h0, w, 1'b0, t, i, h};
  endfunction
  // Sampling at the falling edge keeps clear of the design's updates
  task automatic op(input vcfa_op_t o, input logic [63:0] e, s, input logic fexp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    chk("req_ready", 64'h1, {63'h0, req_ready});
    @(posedge clk);
    req_valid   <= 1'b1;
    req_op      <= o;
    enc_operand <= e;
    src_data    <= s;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (resp_valid !== 1'b1 && n < 3000);
    // A response that never comes counts as a mismatch here
    chk("resp_valid", 64'h1, {63'h0, resp_valid});
    f = resp_fail;
    d = rd_data;
    chk("resp_fail", {63'h0, fexp}, {63'h0, f});
  endtask
  task automatic rd(input logic [63:0] e, exp);
    op(OP_READ, e, 64'h0, 1'b0);
    chk("rd_data", exp, d);
  endtask
  task automatic do_reset(input logic strap);
    int n;
    @(posedge clk);
    ext64_strap <= strap;
    sys_rst     <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 8);
    chk("req_ready", 64'h1, {63'h0, req_ready});
    chk("ext64_cap", {63'h0, strap}, {63'h0, ext64_cap});
    chk("struct_active", 64'h0, {63'h0, struct_active});
  endtask
  ////////////////////////////////////////
  task automatic t_load;
    op(OP_READ, mk(WIDTH_32, TYPE_CTRL, 9'h1, 1'b0), 64'h0, 1'b1);
    op(OP_LOAD, 64'h0, REGION, 1'b0);
    chk("struct_region", REGION, struct_region);
    op(OP_LOAD, 64'h0, REGION, 1'b1);
    // Every slot is given a known value so the flush never carries unknowns
    for (int k = 0; k < 256; k++) begin
      op(OP_WRITE, mk(k[5:4], k[7:6], 9'(k[3:0]), 1'b0), 64'h0, 1'b0);
    end
  endtask
  task automatic t_widths;
    logic [63:0] e, ex;
    for (int t = 0; t < 4; t++) begin
      for (int w = 0; w < 4; w++) begin
        e  = mk(w[1:0], t[1:0], 9'(t * 4 + w), 1'b0);
        ex = (w == 0) ? {48'h0, PAT[15:0]} : (w == 2) ? {32'h0, PAT[31:0]} : PAT;
        op(OP_WRITE, e, PAT, 1'b0);
        rd(e, ex);
      end
    end
  endtask
  task automatic t_high;
    op(OP_WRITE, e64, PAT, 1'b0);
    op(OP_WRITE, e64 | 64'h1, 64'hAAAA_BBBB_1234_5678, 1'b0);
    rd(e64, {32'h1234_5678, PAT[31:0]});
    rd(e64 | 64'h1, 64'h0000_0000_1234_5678);
  endtask
  task automatic t_narrow;
    @(posedge clk);
    long_mode <= 1'b0;
    op(OP_WRITE, e64 | 64'hF000_0000_0000_0000, 64'h1111_2222_3333_4444, 1'b0);
    op(OP_WRITE, e64 | 64'h1, 64'h5555_6666, 1'b0);
    rd(e64, 64'h3333_4444);
    rd(e64 | 64'h1, 64'h5555_6666);
    op(OP_WRITE, enat, PAT, 1'b0);
    rd(enat, {32'h0, PAT[31:0]});
    @(posedge clk);
    long_mode <= 1'b1;
    rd(e64, 64'h5555_6666_3333_4444);
  endtask
  task automatic t_fail;
    logic [63:0] base;
    logic [63:0] bad [6];
    base = mk(WIDTH_16, TYPE_HOST, 9'h0C, 1'b0);
    bad  = '{64'h8000, 64'h8000_0000, 64'h1000, 64'h1_0000_0000, 64'h1, 64'h20};
    foreach (bad[k]) begin
      op(OP_WRITE, base | bad[k], 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
      rd(base, 64'h3210);
    end
  endtask
  task automatic t_flush;
    op(OP_FLUSH, 64'h0, REGION + 64'h1000, 1'b0);
    chk("struct_active", 64'h1, {63'h0, struct_active});
    chk("mem writes", 64'h0, 64'(vcfa_mem_model_i.n_wr));
    @(posedge clk);
    slow <= 1'b1;
    op(OP_FLUSH, 64'h0, REGION, 1'b0);
    chk("struct_active", 64'h0, {63'h0, struct_active});
    chk("mem writes", 64'h100, 64'(vcfa_mem_model_i.n_wr));
    chk("flushed field", 64'h5555_6666_3333_4444, vcfa_mem_model_i.mem[8'h97]);
    chk("flushed zero field", 64'h0, vcfa_mem_model_i.mem[8'h01]);
    op(OP_READ, e64, 64'h0, 1'b1);
  endtask
  // Without the extension long mode is ignored and natural width is 32 bits
  task automatic t_nocap;
    do_reset(1'b0);
    op(OP_LOAD, 64'h0, REGION, 1'b0);
    op(OP_WRITE, enat | 64'h100_0000_0000, PAT, 1'b0);
    rd(enat, {32'h0, PAT[31:0]});
  endtask
  ////////////////////////////////////////
  initial begin
    e64  = mk(WIDTH_64, TYPE_GUEST, 9'h7, 1'b0);
    enat = mk(WIDTH_NAT, TYPE_RO, 9'h2, 1'b0);
    do_reset(1'b1);
    t_load;
    t_widths;
    t_high;
    t_narrow;
    t_fail;
    t_flush;
    t_nocap;
    end_of_test;
  end
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end
endmodule // vcfa_top_tb
`default_nettype wire
